// ==== hw/pbm_map.vh ====
`ifndef PBM_MAP_VH
`define PBM_MAP_VH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define PBM_ADDR_W 4
`define PBM_DATA_W 8
`define PBM_NPINS 4

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PBM_OFS_DIR 4'h0
`define PBM_OFS_ANA 4'h1
`define PBM_OFS_LAT 4'h2
`define PBM_OFS_PORT 4'h3
`define PBM_OFS_IOCEN 4'h4
`define PBM_OFS_STAT 4'h5
`define PBM_OFS_CFG 4'h6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PBM_RST_DIR 4'hf
`define PBM_RST_ANA 4'hf
`define PBM_RST_LAT 4'h0
`define PBM_RST_IOCEN 2'h0
`define PBM_RST_CFG 5'h0f
`define PBM_RST_SNAP 2'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PBM_CFG_PWM2B 0
`define PBM_CFG_T3CLK 1
`define PBM_CFG_CC3 2
`define PBM_CFG_CC2 3
`define PBM_CFG_LARGE 4
`define PBM_CFG_W 5
`define PBM_STAT_CHG 0
`define PBM_IOC_W 2
`define PBM_IOC_LO 2
`define PBM_IOC_HI 3

// ----------------------------------------------------------------
// Pin indices (index 0 is port pin 2)
// ----------------------------------------------------------------
`define PBM_P2 0
`define PBM_P3 1
`define PBM_P4 2
`define PBM_P5 3

`endif

// ==== hw/pbm_mid_pin_mux.v ====
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "pbm_map.vh"

module pbm_mid_pin_mux (
  // Clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // Register port
  input wire [`PBM_ADDR_W-1:0] i_addr,
  input wire [`PBM_DATA_W-1:0] i_wr_data,
  input wire i_wr_stb,
  input wire i_rd_stb,
  output reg [`PBM_DATA_W-1:0] o_rd_data,
  // Pads, index 0 is port pin 2
  input wire [`PBM_NPINS-1:0] i_pin_in,
  output reg [`PBM_NPINS-1:0] o_pin_out,
  output reg [`PBM_NPINS-1:0] o_pin_oe,
  output reg [`PBM_NPINS-1:0] o_analog_conn,
  // Peripheral outputs toward pins
  input wire i_pwm1_output_d,
  input wire i_pwm1_output_d_en,
  input wire i_pwm2_output_b,
  input wire i_pwm2_output_b_en,
  input wire i_capture_compare_3,
  input wire i_capture_compare_3_en,
  input wire i_capture_compare_2,
  input wire i_capture_compare_2_en,
  // Peripheral inputs from pins
  output reg o_comparator_shared_neg_in,
  output reg o_serial2_data_in,
  output reg o_timer5_gate_in,
  output reg o_timer1_gate_in,
  output reg o_timer3_clock_in,
  output reg o_capcmp3_capture_in,
  output reg o_capcmp2_capture_in,
  // Change detect
  output reg o_change_flag
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Digital input path is live
  function dig_in;
    input dir;
    input ana;
    begin
      dig_in = dir & ~ana;
    end
  endfunction

  // Address match with a strobe
  function hit;
    input stb;
    input [`PBM_ADDR_W-1:0] addr;
    input [`PBM_ADDR_W-1:0] ofs;
    begin
      hit = stb & (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [`PBM_NPINS-1:0] pin_direction_bit;
  reg [`PBM_NPINS-1:0] analog_select_bit;
  reg [`PBM_NPINS-1:0] port_output_latch;
  reg [`PBM_IOC_W-1:0] change_detect_en;
  reg [`PBM_IOC_W-1:0] last_read_level;
  reg [`PBM_CFG_W-1:0] reloc_cfg;

  wire [`PBM_NPINS-1:0] pin_sync;

  wire pwm2b_relocate_cfg;
  wire timer3_clk_relocate_cfg;
  wire capcmp3_relocate_cfg;
  wire capcmp2_relocate_cfg;
  wire large_package;

  reg [`PBM_NPINS-1:0] port_in;
  reg [`PBM_NPINS-1:0] periph_en;
  reg [`PBM_NPINS-1:0] periph_val;
  wire [`PBM_NPINS-1:0] next_pin_out;
  wire [`PBM_NPINS-1:0] next_pin_oe;
  reg [`PBM_DATA_W-1:0] next_rd_data;
  wire [`PBM_IOC_W-1:0] mismatch;
  wire next_change_flag;
  wire port_touch;
  wire flag_clr;
  wire [`PBM_NPINS-1:0] dig_path;
  wire [`PBM_NPINS-1:0] next_analog_conn;
  wire [`PBM_IOC_W-1:0] ioc_level;
  wire [`PBM_IOC_W-1:0] ioc_dig;

  // ----------------------------------------------------------------
  // Pad synchroniser
  // ----------------------------------------------------------------
  // Pad levels are asynchronous; only the second stage is read
  pbm_sync2 #(
    .WIDTH(`PBM_NPINS)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_pin_in),
    .o_sync(pin_sync)
  );

  // ----------------------------------------------------------------
  // Relocation fields
  // ----------------------------------------------------------------
  // Bits reset set, so every function starts on its default pin
  assign pwm2b_relocate_cfg = reloc_cfg[`PBM_CFG_PWM2B];
  assign timer3_clk_relocate_cfg = reloc_cfg[`PBM_CFG_T3CLK];
  assign capcmp3_relocate_cfg = reloc_cfg[`PBM_CFG_CC3];
  assign capcmp2_relocate_cfg = reloc_cfg[`PBM_CFG_CC2];
  // Large package sends serial2 input and pwm2 B to other ports
  assign large_package = reloc_cfg[`PBM_CFG_LARGE];

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Software-written control state
  // Unmapped offsets and the read-only port take no write
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_direction_bit <= `PBM_RST_DIR;
      analog_select_bit <= `PBM_RST_ANA;
      port_output_latch <= `PBM_RST_LAT;
      change_detect_en <= `PBM_RST_IOCEN;
      reloc_cfg <= `PBM_RST_CFG;
    end else begin
      if (hit(i_wr_stb, i_addr, `PBM_OFS_DIR)) begin
        pin_direction_bit <= i_wr_data[`PBM_NPINS-1:0];
      end
      if (hit(i_wr_stb, i_addr, `PBM_OFS_ANA)) begin
        analog_select_bit <= i_wr_data[`PBM_NPINS-1:0];
      end
      if (hit(i_wr_stb, i_addr, `PBM_OFS_LAT)) begin
        port_output_latch <= i_wr_data[`PBM_NPINS-1:0];
      end
      if (hit(i_wr_stb, i_addr, `PBM_OFS_IOCEN)) begin
        change_detect_en <= i_wr_data[`PBM_IOC_W-1:0];
      end
      if (hit(i_wr_stb, i_addr, `PBM_OFS_CFG)) begin
        reloc_cfg <= i_wr_data[`PBM_CFG_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital input view
  // ----------------------------------------------------------------

  // Analog select forces the digital input bit to zero
  always @* begin
    port_in = pin_sync & ~analog_select_bit;
  end

  // ----------------------------------------------------------------
  // Digital path per pin
  // ----------------------------------------------------------------

  // A pin takes part in digital input only as input with analog off
  genvar k;
  generate
    for (k = 0; k < `PBM_NPINS; k = k + 1) begin : g_dig
      assign dig_path[k] = dig_in(pin_direction_bit[k], analog_select_bit[k]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Peripheral outputs mapped onto pins
  // ----------------------------------------------------------------

  // Per-pin peripheral claim and value
  // On pin 5 capcmp3 wins over pwm2 B when both are enabled
  always @* begin
    periph_en = {`PBM_NPINS{1'b0}};
    periph_val = {`PBM_NPINS{1'b0}};
    // Pin 3: capcmp2 alternate location
    if (~capcmp2_relocate_cfg && i_capture_compare_2_en) begin
      periph_en[`PBM_P3] = 1'b1;
      periph_val[`PBM_P3] = i_capture_compare_2;
    end
    // Pin 4: pwm1 output D
    if (i_pwm1_output_d_en) begin
      periph_en[`PBM_P4] = 1'b1;
      periph_val[`PBM_P4] = i_pwm1_output_d;
    end
    // Pin 5: capcmp3 first, then pwm2 B on its default pin
    if (capcmp3_relocate_cfg && i_capture_compare_3_en) begin
      periph_en[`PBM_P5] = 1'b1;
      periph_val[`PBM_P5] = i_capture_compare_3;
    end else if (pwm2b_relocate_cfg && ~large_package && i_pwm2_output_b_en) begin
      periph_en[`PBM_P5] = 1'b1;
      periph_val[`PBM_P5] = i_pwm2_output_b;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers per pin
  // ----------------------------------------------------------------
  generate
    for (k = 0; k < `PBM_NPINS; k = k + 1) begin : g_pin
      // Driver on when direction is 0; analog select ignored here
      assign next_pin_oe[k] = ~pin_direction_bit[k];
      // Analog channel joined only while the pin is an input
      assign next_analog_conn[k] = pin_direction_bit[k] & analog_select_bit[k];
      // Peripheral wins only with digital mode selected
      assign next_pin_out[k] = (periph_en[k] & ~analog_select_bit[k]) ? periph_val[k] :
                               port_output_latch[k];
    end
  endgenerate

  // Pad-facing flops
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pin_out <= {`PBM_NPINS{1'b0}};
      o_pin_oe <= {`PBM_NPINS{1'b0}};
      o_analog_conn <= {`PBM_NPINS{1'b0}};
    end else begin
      o_pin_out <= next_pin_out;
      o_pin_oe <= next_pin_oe;
      o_analog_conn <= next_analog_conn;
    end
  end

  // ----------------------------------------------------------------
  // Pin levels routed to peripherals
  // ----------------------------------------------------------------

  // Inputs idle low whenever their path is not selected
  // Levels lag the pad by three edges: two sync flops and this one
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_comparator_shared_neg_in <= 1'b0;
      o_serial2_data_in <= 1'b0;
      o_timer5_gate_in <= 1'b0;
      o_timer1_gate_in <= 1'b0;
      o_timer3_clock_in <= 1'b0;
      o_capcmp3_capture_in <= 1'b0;
      o_capcmp2_capture_in <= 1'b0;
    end else begin
      // Connect flag for the analog comparator input
      o_comparator_shared_neg_in <= pin_direction_bit[`PBM_P3] & analog_select_bit[`PBM_P3];
      // Serial data input moves off-port on the large package
      o_serial2_data_in <= dig_in(pin_direction_bit[`PBM_P2], analog_select_bit[`PBM_P2]) &
                           ~large_package & pin_sync[`PBM_P2];
      o_timer5_gate_in <= dig_in(pin_direction_bit[`PBM_P4], analog_select_bit[`PBM_P4]) &
                          pin_sync[`PBM_P4];
      o_timer1_gate_in <= dig_in(pin_direction_bit[`PBM_P5], analog_select_bit[`PBM_P5]) &
                          pin_sync[`PBM_P5];
      // Timer3 clock lands here only when relocated
      o_timer3_clock_in <= dig_in(pin_direction_bit[`PBM_P5], analog_select_bit[`PBM_P5]) &
                           ~timer3_clk_relocate_cfg & pin_sync[`PBM_P5];
      // Capcmp3 capture on its default pin
      o_capcmp3_capture_in <= dig_in(pin_direction_bit[`PBM_P5], analog_select_bit[`PBM_P5]) &
                              capcmp3_relocate_cfg & pin_sync[`PBM_P5];
      // Capcmp2 capture on its alternate pin
      o_capcmp2_capture_in <= dig_in(pin_direction_bit[`PBM_P3], analog_select_bit[`PBM_P3]) &
                              ~capcmp2_relocate_cfg & pin_sync[`PBM_P3];
    end
  end

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------

  // Port read or latch write ends the mismatch
  assign port_touch = hit(i_rd_stb, i_addr, `PBM_OFS_PORT) | hit(i_wr_stb, i_addr, `PBM_OFS_LAT);
  assign flag_clr = hit(i_wr_stb, i_addr, `PBM_OFS_STAT) & i_wr_data[`PBM_STAT_CHG];

  // Levels and digital paths of the two change-detect pins
  assign ioc_level = pin_sync[`PBM_IOC_HI:`PBM_IOC_LO];
  assign ioc_dig = dig_path[`PBM_IOC_HI:`PBM_IOC_LO];

  // Only enabled digital inputs take part
  assign mismatch = change_detect_en & ioc_dig & (ioc_level ^ last_read_level);

  // Set wins over a clear in the same cycle
  assign next_change_flag = (o_change_flag & ~flag_clr) | (|mismatch);

  // Last-read snapshot and sticky flag
  // Snapshot clears on reset, so a high level at release shows as a change
  // A change meeting the port read in one edge still sets the flag
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_read_level <= `PBM_RST_SNAP;
      o_change_flag <= 1'b0;
    end else begin
      if (port_touch) begin
        last_read_level <= ioc_level;
      end
      o_change_flag <= next_change_flag;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  // Read mux, unmapped offsets answer zero
  // Only a port read has a side effect: it reloads the snapshot
  always @* begin
    next_rd_data = {`PBM_DATA_W{1'b0}};
    if (i_rd_stb) begin
      case (i_addr)
        `PBM_OFS_DIR: next_rd_data[`PBM_NPINS-1:0] = pin_direction_bit;
        `PBM_OFS_ANA: next_rd_data[`PBM_NPINS-1:0] = analog_select_bit;
        `PBM_OFS_LAT: next_rd_data[`PBM_NPINS-1:0] = port_output_latch;
        `PBM_OFS_PORT: next_rd_data[`PBM_NPINS-1:0] = port_in;
        `PBM_OFS_IOCEN: next_rd_data[`PBM_IOC_W-1:0] = change_detect_en;
        `PBM_OFS_STAT: next_rd_data[`PBM_STAT_CHG] = o_change_flag;
        `PBM_OFS_CFG: next_rd_data[`PBM_CFG_W-1:0] = reloc_cfg;
        default: next_rd_data = {`PBM_DATA_W{1'b0}};
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= {`PBM_DATA_W{1'b0}};
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

endmodule // pbm_mid_pin_mux

// ==== hw/pbm_sync2.v ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-flop synchroniser for pad levels
// ----------------------------------------------------------------
module pbm_sync2 #(
  parameter WIDTH = 4
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_sys_rst,
  // Levels in and out
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // pbm_sync2

// ==== sim/pbm_chk.sv ====
`timescale 1ns/1ps
`include "pbm_map.vh"
// ------------------------------
// Port checker
// ------------------------------
module pbm_chk (
  // Clock, reset, register writes
  input wire i_mclk,
  input wire i_sys_rst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr_stb,
  // Pads and peripherals
  input wire [3:0] i_pin_in,
  input wire [3:0] o_pin_out,
  input wire [3:0] o_pin_oe,
  input wire [3:0] o_analog_conn,
  input wire i_pwm1_output_d,
  input wire i_pwm1_output_d_en,
  input wire i_capture_compare_3,
  input wire i_capture_compare_3_en,
  input wire o_comparator_shared_neg_in,
  input wire o_serial2_data_in,
  input wire o_timer5_gate_in,
  input wire o_timer1_gate_in,
  input wire o_timer3_clock_in
);
  reg [3:0] dir_s;
  reg [3:0] ana_s;
  reg [3:0] lat_s;
  reg [4:0] cfg_s;
  reg [1:0] live;
  wire [3:0] dig = dir_s & ~ana_s;
  wire ok = (live == 2'h3);

  // Shadow of the control registers, age since reset
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dir_s <= `PBM_RST_DIR;
      ana_s <= `PBM_RST_ANA;
      lat_s <= `PBM_RST_LAT;
      cfg_s <= `PBM_RST_CFG;
      live <= 2'h0;
    end else begin
      if (!ok) live <= live + 2'h1;
      if (i_wr_stb && i_addr == `PBM_OFS_DIR) dir_s <= i_wr_data[3:0];
      if (i_wr_stb && i_addr == `PBM_OFS_ANA) ana_s <= i_wr_data[3:0];
      if (i_wr_stb && i_addr == `PBM_OFS_LAT) lat_s <= i_wr_data[3:0];
      if (i_wr_stb && i_addr == `PBM_OFS_CFG) cfg_s <= i_wr_data[4:0];
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  a_oe_dir: assert property (ok |-> o_pin_oe == ~$past(dir_s))
    else $error("pin enable not inverse of direction");
  a_latch_out: assert property (ok |-> o_pin_out[0] == $past(lat_s[0]))
    else $error("pin 2 not driven from latch");
  a_ana_conn: assert property (ok |-> o_analog_conn == $past(dir_s & ana_s))
    else $error("analog connect wrong");
  a_pwm1_claim: assert property (ok && $past(i_pwm1_output_d_en & ~ana_s[2]) |-> o_pin_out[2] == $past(i_pwm1_output_d))
    else $error("pin 4 not carrying pwm1 D");
  a_cc3_claim: assert property (ok && $past(i_capture_compare_3_en & cfg_s[2] & ~ana_s[3])
    |-> o_pin_out[3] == $past(i_capture_compare_3))
    else $error("pin 5 not carrying compare 3");
  a_comp_neg: assert property (ok |-> o_comparator_shared_neg_in == $past(dir_s[1] & ana_s[1]))
    else $error("comparator input connect wrong");
  a_serial_in: assert property (ok |-> o_serial2_data_in == ($past(dig[0] & ~cfg_s[4]) & $past(i_pin_in[0], 3)))
    else $error("serial data input wrong");
  a_t5_gate: assert property (ok |-> o_timer5_gate_in == ($past(dig[2]) & $past(i_pin_in[2], 3)))
    else $error("timer5 gate wrong");
  a_t1_gate: assert property (ok |-> o_timer1_gate_in == ($past(dig[3]) & $past(i_pin_in[3], 3)))
    else $error("timer1 gate wrong");
  a_t3_clk: assert property (ok |-> o_timer3_clock_in == ($past(dig[3] & ~cfg_s[1]) & $past(i_pin_in[3], 3)))
    else $error("timer3 clock wrong");

  c_comp: cover property (o_comparator_shared_neg_in);
  c_t3: cover property (o_timer3_clock_in);
  c_pwm1: cover property (i_pwm1_output_d_en && o_pin_oe[2]);
endmodule // pbm_chk

bind pbm_mid_pin_mux pbm_chk u_chk (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .o_analog_conn(o_analog_conn), .i_pwm1_output_d(i_pwm1_output_d),
  .i_pwm1_output_d_en(i_pwm1_output_d_en), .i_capture_compare_3(i_capture_compare_3),
  .i_capture_compare_3_en(i_capture_compare_3_en), .o_comparator_shared_neg_in(o_comparator_shared_neg_in),
  .o_serial2_data_in(o_serial2_data_in), .o_timer5_gate_in(o_timer5_gate_in),
  .o_timer1_gate_in(o_timer1_gate_in), .o_timer3_clock_in(o_timer3_clock_in));

// ==== sim/pbm_pad_model.sv ====
`timescale 1ns/1ps
// ------------------------------
// Pads and peripheral sources
// ------------------------------
module pbm_pad_model (
  // Clock
  input wire i_mclk,
  // Requests from the bench
  input wire [3:0] i_ext,
  input wire [3:0] i_per,
  input wire [3:0] i_per_en,
  // Pad drive from the block
  input wire [3:0] i_pin_out,
  input wire [3:0] i_pin_oe,
  // Toward the block
  output wire [3:0] o_pin_in,
  output reg [3:0] o_per,
  output reg [3:0] o_per_en
);
  // Pad shows the block's drive, else the outside level
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);

  // Peripherals change just after the clock edge
  always @(posedge i_mclk) begin
    o_per <= i_per;
    o_per_en <= i_per_en;
  end
endmodule // pbm_pad_model

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`include "pbm_map.vh"
module tb;
  reg i_mclk = 1'b0;
  reg i_sys_rst = 1'b1;
  reg [3:0] i_addr = 4'h0;
  reg [7:0] i_wr_data = 8'h00;
  reg i_wr_stb = 1'b0;
  reg i_rd_stb = 1'b0;
  reg [3:0] ext = 4'h0;
  reg [3:0] per = 4'h0;
  reg [3:0] per_en = 4'h0;
  integer fails = 0;
  integer checks_done = 0;
  wire [7:0] rd_data;
  wire [3:0] pin_in, pin_out, pin_oe, ana_conn, per_q, en_q;
  wire cmp, sdi, t5, t1, t3, cap3, cap2, chg;
  wire [7:0] ins = {1'b0, cmp, sdi, t5, t1, t3, cap3, cap2};

  // Clock at 20 MHz
  always #25 i_mclk = ~i_mclk;

  pbm_pad_model i_pad (.i_mclk(i_mclk), .i_ext(ext), .i_per(per), .i_per_en(per_en), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_pin_in(pin_in), .o_per(per_q), .o_per_en(en_q));
  pbm_mid_pin_mux i_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(rd_data), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_analog_conn(ana_conn), .i_pwm1_output_d(per_q[0]), .i_pwm1_output_d_en(en_q[0]),
    .i_pwm2_output_b(per_q[1]), .i_pwm2_output_b_en(en_q[1]), .i_capture_compare_3(per_q[2]),
    .i_capture_compare_3_en(en_q[2]), .i_capture_compare_2(per_q[3]), .i_capture_compare_2_en(en_q[3]),
    .o_comparator_shared_neg_in(cmp), .o_serial2_data_in(sdi), .o_timer5_gate_in(t5), .o_timer1_gate_in(t1),
    .o_timer3_clock_in(t3), .o_capcmp3_capture_in(cap3), .o_capcmp2_capture_in(cap2), .o_change_flag(chg));

  // ------------------------------
  // Bus and compare tasks
  // ------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      i_rd_stb <= 1'b0;
      i_wr_stb <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_mclk);
    end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      i_wr_stb <= 1'b0;
      i_rd_stb <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      #1;
      chk(rd_data, exp);
    end
  endtask
  task cyc(input integer n);
    begin
      i_wr_stb <= 1'b0;
      i_rd_stb <= 1'b0;
      repeat (n) @(posedge i_mclk);
      #1;
    end
  endtask
  task ins_case(input [3:0] e, input [7:0] cfg, input [7:0] ana, input [7:0] exp);
    begin
      ext <= e;
      wr(`PBM_OFS_CFG, cfg);
      wr(`PBM_OFS_ANA, ana);
      cyc(4);
      chk(ins, exp);
    end
  endtask
  task final_report;
    begin
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  // ------------------------------
  // Test sequence
  // ------------------------------
  initial begin
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    cyc(1);
    rd(`PBM_OFS_DIR, 8'h0f);
    rd(`PBM_OFS_ANA, 8'h0f);
    rd(`PBM_OFS_LAT, 8'h00);
    rd(`PBM_OFS_CFG, 8'h0f);
    rd(4'h7, 8'h00);
    ext <= 4'ha;
    wr(`PBM_OFS_ANA, 8'h00);
    cyc(4);
    rd(`PBM_OFS_PORT, 8'h0a);
    wr(`PBM_OFS_ANA, 8'h03);
    cyc(3);
    rd(`PBM_OFS_PORT, 8'h08);
    ins_case(4'hf, 8'h0f, 8'h00, 8'h3a);
    ins_case(4'h5, 8'h0f, 8'h00, 8'h30);
    ins_case(4'hf, 8'h10, 8'h00, 8'h1d);
    ins_case(4'hf, 8'h10, 8'h0f, 8'h40);
    chk({4'h0, ana_conn}, 8'h0f);
    // Drive side: latch, then peripheral claims
    wr(`PBM_OFS_CFG, 8'h0f);
    wr(`PBM_OFS_LAT, 8'h05);
    wr(`PBM_OFS_DIR, 8'h00);
    cyc(2);
    chk({4'h0, pin_oe}, 8'h0f);
    chk({4'h0, pin_out}, 8'h05);
    wr(`PBM_OFS_ANA, 8'h00);
    wr(`PBM_OFS_LAT, 8'h0a);
    per <= 4'h3;
    per_en <= 4'hf;
    cyc(3);
    chk({4'h0, pin_out}, 8'h06);
    wr(`PBM_OFS_CFG, 8'h03);
    cyc(2);
    chk({4'h0, pin_out}, 8'h0c);
    // Large package keeps pwm2 B off pin 5, latch shows instead
    wr(`PBM_OFS_CFG, 8'h13);
    wr(`PBM_OFS_LAT, 8'h02);
    cyc(2);
    chk({4'h0, pin_out}, 8'h04);
    per_en <= 4'h0;
    cyc(3);
    chk({4'h0, pin_out}, 8'h02);
    // Change detect on pins 4 and 5
    ext <= 4'h0;
    wr(`PBM_OFS_DIR, 8'h0f);
    wr(`PBM_OFS_IOCEN, 8'h03);
    cyc(4);
    rd(`PBM_OFS_PORT, 8'h00);
    wr(`PBM_OFS_STAT, 8'h01);
    cyc(3);
    chk({7'h0, chg}, 8'h00);
    ext <= 4'h4;
    cyc(5);
    chk({7'h0, chg}, 8'h01);
    rd(`PBM_OFS_STAT, 8'h01);
    rd(`PBM_OFS_PORT, 8'h04);
    wr(`PBM_OFS_STAT, 8'h01);
    cyc(2);
    chk({7'h0, chg}, 8'h00);
    ext <= 4'h5;
    cyc(5);
    chk({7'h0, chg}, 8'h00);
    final_report;
  end

  // Watchdog far beyond the hundred or so cycles needed
  initial begin
    #(3000 * 50);
    fails = fails + 1;
    final_report;
  end
endmodule // tb
